// *** dv/slsm_host_model.sv ***
/*
 Host model: drives the command levels and a periodic frame pulse.
 Assumes bench requests change just after a rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module slsm_host_model #(
  parameter int FRAME_PER = 16,
  parameter int WD_TIME = 50
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the bench
  input wire logic fv_set,
  input wire logic fault_set,
  input wire logic oa_set,
  input wire logic frames_on,
  // Levels toward the device
  output logic fv_cmd,
  output logic link_fault,
  output logic oa_cmd,
  output logic frame_rx
);
  int cnt;

  // Register requests and pace frames
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fv_cmd <= 1'b0;
      link_fault <= 1'b0;
      oa_cmd <= 1'b0;
      frame_rx <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      fv_cmd <= fv_set;
      link_fault <= fault_set;
      oa_cmd <= oa_set;
      cnt <= (cnt == FRAME_PER - 1) ? 0 : cnt + 1;
      // Frame period well over 30% below the device watchdog
      frame_rx <= frames_on && (cnt < FRAME_PER / 2);
    end
  end
endmodule

`default_nettype wire

// *** dv/testbench.sv ***
/*
 Self-checking bench: APB tasks, host model, state walk.
 Assumes slsm_top with WD_CYC and DAT_CYC shortened to 50.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic oa_cmd, fv_cmd, link_fault, frame_rx;
  logic [2:0] state;
  logic oa_req, frame_tx, irq;
  logic fv_set = 1'b1;
  logic fault_set = 1'b0;
  logic oa_set = 1'b0;
  logic frames_on = 1'b1;
  logic [31:0] q;
  logic e;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  slsm_top #(.WD_CYC(50), .DAT_CYC(50)) u_slsm_top (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .oa_cmd, .fv_cmd, .link_fault, .frame_rx, .state,
    .oa_req, .frame_tx, .irq);

  slsm_host_model u_slsm_host_model (.pclk, .presetn, .fv_set,
    .fault_set, .oa_set, .frames_on, .fv_cmd, .link_fault, .oa_cmd,
    .frame_rx);

  // Clock
  always #2 pclk = ~pclk;

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Control word, host levels, optional acknowledge edge, then state
  task automatic step(input logic [7:0] c, input logic f,
                      input logic l, input logic o, input logic [2:0] s);
    apb(1'b1, 12'h000, {24'h000000, c});
    fv_set <= f;
    fault_set <= l;
    oa_set <= o;
    wt(10);
    chk(state, s);
    oa_set <= 1'b0;
    wt(6);
  endtask

  // Main sequence
  initial
  begin
    wt(6);
    presetn <= 1'b1;
    @(posedge frame_rx);
    n = 0;
    while (frame_tx !== 1'b1 && n < 80)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n <= 58, 1'b1);
    chk(state, 3'd3);
    step(8'h00, 1'b0, 1'b0, 1'b0, 3'd1);
    step(8'h04, 1'b0, 1'b0, 1'b0, 3'd4);
    step(8'h04, 1'b1, 1'b0, 1'b0, 3'd3);
    step(8'h04, 1'b0, 1'b0, 1'b0, 3'd4);
    step(8'h04, 1'b0, 1'b1, 1'b0, 3'd2);
    step(8'h04, 1'b0, 1'b0, 1'b0, 3'd5);
    chk(oa_req, 1'b1);
    step(8'h04, 1'b0, 1'b0, 1'b1, 3'd4);
    step(8'h00, 1'b0, 1'b1, 1'b0, 3'd2);
    step(8'h00, 1'b0, 1'b0, 1'b0, 3'd5);
    step(8'h00, 1'b0, 1'b0, 1'b1, 3'd1);
    step(8'h00, 1'b0, 1'b1, 1'b0, 3'd2);
    step(8'h00, 1'b0, 1'b0, 1'b0, 3'd5);
    step(8'h00, 1'b1, 1'b0, 1'b0, 3'd3);
    step(8'h22, 1'b1, 1'b0, 1'b0, 3'd6);
    step(8'h01, 1'b1, 1'b0, 1'b0, 3'd3);
    step(8'h60, 1'b1, 1'b0, 1'b0, 3'd3);
    step(8'h20, 1'b1, 1'b0, 1'b0, 3'd7);
    step(8'h22, 1'b0, 1'b1, 1'b0, 3'd7);
    step(8'h01, 1'b0, 1'b1, 1'b0, 3'd2);
    step(8'h00, 1'b0, 1'b0, 1'b0, 3'd5);
    step(8'h00, 1'b0, 1'b0, 1'b1, 3'd1);
    // Starve the watchdog while operational
    frames_on <= 1'b0;
    wt(30);
    chk(state, 3'd1);
    wt(40);
    chk(state, 3'd5);
    apb(1'b0, 12'h008, 32'h0);
    chk(q[1], 1'b1);
    frames_on <= 1'b1;
    step(8'h20, 1'b0, 1'b0, 1'b0, 3'd7);
    apb(1'b0, 12'h004, 32'h0);
    chk(q[2:0], 3'd7);
    // Interrupt mask and clear on the state-change bit
    apb(1'b1, 12'h00C, 32'h0);
    wt(4);
    chk(irq, 1'b0);
    apb(1'b1, 12'h00C, 32'h1);
    wt(4);
    chk(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h1);
    wt(4);
    chk(irq, 1'b0);
    // Frame prepared on software kick
    @(posedge frame_rx);
    wt(6);
    apb(1'b1, 12'h010, 32'h1);
    n = 0;
    while (frame_tx !== 1'b1 && n < 3)
    begin
      @(posedge pclk);
      n++;
    end
    chk(frame_tx, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    print_verdict();
  end
endmodule

`default_nettype wire

// *** hw/slsm_params.svh ***
/*
 * Constants of the safety link state controller: register offsets,
 * field positions and timing figures.
 * Assumes a 250 MHz pclk and an APB register bus with 32-bit data.
 */
`ifndef SLSM_PARAMS_SVH
`define SLSM_PARAMS_SVH

// Clock period in picoseconds
`define SLSM_CLK_PS 4000
// Device watchdog and acknowledgement time, in ms
`define SLSM_WD_MS 50
`define SLSM_DAT_MS 50
// Cycles in one millisecond
`define SLSM_CYC_PER_MS (1000000000 / `SLSM_CLK_PS)
// Cycle counts derived from the times above
`define SLSM_WD_CYC (`SLSM_WD_MS * `SLSM_CYC_PER_MS)
`define SLSM_DAT_CYC (`SLSM_DAT_MS * `SLSM_CYC_PER_MS)

// Register byte offsets
`define SLSM_CTRL_ADDR 12'h000
`define SLSM_STAT_ADDR 12'h004
`define SLSM_IRQ_ADDR 12'h008
`define SLSM_MASK_ADDR 12'h00C
`define SLSM_KICK_ADDR 12'h010

// Control bits
`define SLSM_CTRL_REBOOT 0
`define SLSM_CTRL_FATAL 1
`define SLSM_CTRL_SFERR 2
`define SLSM_CTRL_PEND 3
`define SLSM_CTRL_MODERR 4
`define SLSM_CTRL_TOOL 5
`define SLSM_CTRL_MOTOR 6
`define SLSM_CTRL_W 7

// Interrupt bits
`define SLSM_IRQ_STATE 0
`define SLSM_IRQ_WD 1
`define SLSM_IRQ_DAT 2
`define SLSM_IRQ_W 3

// Status word layout
`define SLSM_STAT_STATE_LSB 0
`define SLSM_STAT_OAREQ 4
`define SLSM_STAT_FV 5

`endif

// *** hw/slsm_pkg.sv ***
/*
 * Types of the safety link state controller.
 * Assumes nothing of its surroundings.
 */
package slsm_pkg;

  // Operating states
  typedef enum logic [2:0]
  {
    SLSM_STARTUP,
    SLSM_OPER,
    SLSM_PASS,
    SLSM_PASS_CMD,
    SLSM_PASS_REINT,
    SLSM_ACK_REQ,
    SLSM_FAILSAFE,
    SLSM_CONFIG
  } slsm_state_e;

endpackage

// *** hw/slsm_sync.sv ***
/*
 * Three-flop input synchroniser with agreement filter.
 * Assumes an asynchronous input and a single pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module slsm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire [WIDTH-1:0] agree = ~(s2 ^ s3);
  wire [WIDTH-1:0] next_dout = (agree & s3) | (~agree & dout);

  // Shift chain; output moves only once two stages agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end

endmodule

`default_nettype wire

// *** hw/slsm_top.sv ***
/*
 * Operating-state controller of a safety functions module acting as
 * the device end of a safety fieldbus connection, with device watchdog,
 * acknowledgement timer and an APB register file.
 * Assumes host commands and link faults arrive as asynchronous levels;
 * software gives self-test, error and tool status over APB.
 */
// Register access over APB and the address map were decided locally.
// Summary of operation
// RL1: Acknowledge edge, no errors: go Operational
// RL2: Fail-value command while awaiting ack: command passivation
// RL3: Command cleared with ack request: await acknowledge (here never taken; a pending ack goes to reintegration)
// RL4: Fatal self-test error in command passivation: Fail-safe
// RL5: Power cycle or reboot: back to Start-up
// RL6: Command cleared, no module error: Operational
// RL7: Reintegration plus link fault: plain passivation
// RL8: Reintegration plus fail-value command: command passivation
// RL9: Acknowledge edge with errors: reintegration
// RL10: Command cleared with errors: reintegration
// RL11: Motor stopped and tool connects: Configuration (here not taken from Fail-safe)
// RL12: Configuration leaves only to Start-up
// RL13: Internal watchdog bounds delay at 50 ms
// RL14: Frame processed within 50 ms acknowledgement
// RL15: Host watchdog exceeds minimum watchdog time
// RL16: Host watchdog about 30% above cycle
// RL17: Operational plus link fault: plain passivation
// RL18: Operational plus safety-function problem: reintegration
// RL19: One state; fatal error has top priority (here a reboot wins over it, and Configuration ignores it)
`timescale 1ns/1ps
`default_nettype none
`include "slsm_params.svh"

module slsm_top #(
  parameter int WD_CYC = `SLSM_WD_CYC,
  parameter int DAT_CYC = `SLSM_DAT_CYC
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host command levels and link events (asynchronous)
  input wire logic oa_cmd,
  input wire logic fv_cmd,
  input wire logic link_fault,
  input wire logic frame_rx,
  // Status to the host and system
  output logic [2:0] state,
  output logic oa_req,
  output logic frame_tx,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [3:0] sync_q;
  slsm_sync #(.WIDTH(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({frame_rx, link_fault, fv_cmd, oa_cmd}),
    .dout(sync_q)
  );
  wire oa_s = sync_q[0];
  wire fv_s = sync_q[1];
  wire fault_s = sync_q[2];
  wire frame_s = sync_q[3];
  logic oa_d;
  logic frame_d;
  wire oa_rise = oa_s & ~oa_d;
  wire frame_rise = frame_s & ~frame_d;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [`SLSM_CTRL_W-1:0] ctrl;
  logic [`SLSM_IRQ_W-1:0] irq_stat;
  logic [`SLSM_IRQ_W-1:0] irq_mask;
  slsm_pkg::slsm_state_e cur;
  slsm_pkg::slsm_state_e next_cur;
  logic [31:0] wd_cnt;
  logic [31:0] dat_cnt;
  logic dat_busy;

  // Bus decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = paddr == `SLSM_CTRL_ADDR;
  wire hit_stat = paddr == `SLSM_STAT_ADDR;
  wire hit_irq = paddr == `SLSM_IRQ_ADDR;
  wire hit_mask = paddr == `SLSM_MASK_ADDR;
  wire hit_kick = paddr == `SLSM_KICK_ADDR;
  wire mapped = hit_ctrl | hit_stat | hit_irq | hit_mask | hit_kick;
  wire kick = wr & hit_kick;
  wire reboot = wr & hit_ctrl & pwdata[`SLSM_CTRL_REBOOT];

  // Software-given conditions
  wire fatal = ctrl[`SLSM_CTRL_FATAL];
  wire sf_err = ctrl[`SLSM_CTRL_SFERR];
  wire pend = ctrl[`SLSM_CTRL_PEND];
  wire mod_err = ctrl[`SLSM_CTRL_MODERR];
  wire tool = ctrl[`SLSM_CTRL_TOOL];
  wire motor = ctrl[`SLSM_CTRL_MOTOR];
  wire errs = sf_err | pend;

  // Watchdog and acknowledgement timer expiry
  wire wd_exp = wd_cnt == 32'(WD_CYC - 1); // RL13
  wire dat_exp = dat_busy & (dat_cnt == 32'(DAT_CYC - 1)); // RL14
  wire comm_fault = fault_s | wd_exp;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_cur = cur;
    case (cur)
      slsm_pkg::SLSM_STARTUP:
        if (comm_fault)
          next_cur = slsm_pkg::SLSM_PASS;
        else
          next_cur = slsm_pkg::SLSM_PASS_CMD;
      slsm_pkg::SLSM_OPER:
        if (comm_fault)
          next_cur = slsm_pkg::SLSM_PASS; // RL17
        else if (fv_s)
          next_cur = slsm_pkg::SLSM_PASS_CMD;
        else if (sf_err)
          next_cur = slsm_pkg::SLSM_PASS_REINT; // RL18
      slsm_pkg::SLSM_PASS:
        if (!comm_fault && !mod_err)
          next_cur = fv_s ? slsm_pkg::SLSM_PASS_CMD
                          : slsm_pkg::SLSM_ACK_REQ;
      slsm_pkg::SLSM_PASS_CMD:
        if (comm_fault)
          next_cur = slsm_pkg::SLSM_PASS;
        else if (!fv_s && errs)
          next_cur = slsm_pkg::SLSM_PASS_REINT; // RL10
        else if (!fv_s && oa_req)
          next_cur = slsm_pkg::SLSM_ACK_REQ; // RL3
        else if (!fv_s && !mod_err)
          next_cur = slsm_pkg::SLSM_OPER; // RL6
      slsm_pkg::SLSM_PASS_REINT:
        if (comm_fault)
          next_cur = slsm_pkg::SLSM_PASS; // RL7
        else if (fv_s)
          next_cur = slsm_pkg::SLSM_PASS_CMD; // RL8
        else if (!errs)
          next_cur = slsm_pkg::SLSM_OPER;
      slsm_pkg::SLSM_ACK_REQ:
        if (comm_fault)
          next_cur = slsm_pkg::SLSM_PASS;
        else if (fv_s)
          next_cur = slsm_pkg::SLSM_PASS_CMD; // RL2
        else if (oa_rise && errs)
          next_cur = slsm_pkg::SLSM_PASS_REINT; // RL9
        else if (oa_rise)
          next_cur = slsm_pkg::SLSM_OPER; // RL1
      slsm_pkg::SLSM_FAILSAFE:
        next_cur = cur;
      slsm_pkg::SLSM_CONFIG:
        next_cur = cur; // RL12
      default:
        next_cur = slsm_pkg::SLSM_STARTUP;
    endcase
    // Tool connection only while the motor stands still
    if (tool && !motor && cur != slsm_pkg::SLSM_FAILSAFE)
      next_cur = slsm_pkg::SLSM_CONFIG; // RL11
    // Fatal errors override every other move except a reboot, outside Configuration
    if (fatal && cur != slsm_pkg::SLSM_CONFIG)
      next_cur = slsm_pkg::SLSM_FAILSAFE; // RL4 RL19
    // Reboot from any state
    if (reboot)
      next_cur = slsm_pkg::SLSM_STARTUP; // RL5 RL12
  end

  // Acknowledge request raised while command passivation is left pending
  wire next_oa_req = (next_cur == slsm_pkg::SLSM_ACK_REQ) |
                     (cur == slsm_pkg::SLSM_PASS_CMD & ~fv_s & ~mod_err &
                      pend);

  // State and edge registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur <= slsm_pkg::SLSM_STARTUP;
      oa_d <= 1'b0;
      frame_d <= 1'b0;
      oa_req <= 1'b0;
      state <= 3'h0;
    end
    else
    begin
      cur <= next_cur;
      oa_d <= oa_s;
      frame_d <= frame_s;
      oa_req <= next_oa_req;
      state <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device watchdog: restarted by each received frame
  wire wd_run = cur != slsm_pkg::SLSM_STARTUP &&
                cur != slsm_pkg::SLSM_CONFIG &&
                cur != slsm_pkg::SLSM_FAILSAFE;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_cnt <= 32'h0;
    else if (frame_rise || !wd_run || wd_exp)
      wd_cnt <= 32'h0; // RL13
    else
      wd_cnt <= wd_cnt + 32'h1;
  end

  // Acknowledgement timer: a frame must be answered within the budget
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dat_busy <= 1'b0;
      dat_cnt <= 32'h0;
      frame_tx <= 1'b0;
    end
    else
    begin
      frame_tx <= 1'b0;
      // A frame arriving while one is still open does not push the answer out
      if (frame_rise && !dat_busy)
      begin
        dat_busy <= 1'b1;
        dat_cnt <= 32'h0;
      end
      else if (dat_busy && (kick || dat_exp))
      begin
        dat_busy <= 1'b0;
        frame_tx <= 1'b1; // RL14
      end
      else if (dat_busy)
        dat_cnt <= dat_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events, sticky; set wins over clear
  wire [`SLSM_IRQ_W-1:0] ev = {dat_exp, wd_exp, next_cur != cur};
  wire [`SLSM_IRQ_W-1:0] clr = (wr & hit_irq) ?
                               pwdata[`SLSM_IRQ_W-1:0] : '0;

  // Register writes and interrupt state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctrl)
        ctrl <= {pwdata[`SLSM_CTRL_W-1:1], 1'b0};
      if (wr && hit_mask)
        irq_mask <= pwdata[`SLSM_IRQ_W-1:0];
      irq_stat <= (irq_stat & ~clr) | ev;
      irq <= |(((irq_stat & ~clr) | ev) & irq_mask);
    end
  end

  // Read data
  wire [31:0] stat_word = {26'h0, fv_s, oa_req, 1'b0, state};
  wire [31:0] rd_mux = hit_ctrl ? {25'h0, ctrl} :
                       hit_stat ? stat_word :
                       hit_irq ? {29'h0, irq_stat} :
                       hit_mask ? {29'h0, irq_mask} : 32'h0;

  // APB answer in the first cycle of the access phase, one cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_fatal_seen;
    fatal && !reboot && cur != slsm_pkg::SLSM_CONFIG;
  endsequence

  a_fatal_priority: assert property (@(posedge pclk) disable iff (!presetn) s_fatal_seen |=> cur == slsm_pkg::SLSM_FAILSAFE) else $error("fatal not taken"); // RL19
  a_config_exit: assert property (@(posedge pclk) disable iff (!presetn) cur == slsm_pkg::SLSM_CONFIG && !reboot |=> cur == slsm_pkg::SLSM_CONFIG) else $error("config left"); // RL12
  a_reboot_start: assert property (@(posedge pclk) disable iff (!presetn) reboot |=> cur == slsm_pkg::SLSM_STARTUP) else $error("reboot ignored"); // RL5
  a_ack_oper: assert property (@(posedge pclk) disable iff (!presetn) cur == slsm_pkg::SLSM_ACK_REQ && oa_rise && !errs && !fv_s && !comm_fault && !fatal && !reboot && !(tool && !motor) |=> cur == slsm_pkg::SLSM_OPER) else $error("ack not taken"); // RL1
  a_ack_reint: assert property (@(posedge pclk) disable iff (!presetn) cur == slsm_pkg::SLSM_ACK_REQ && oa_rise && errs && !fv_s && !comm_fault && !fatal && !reboot && !(tool && !motor) |=> cur == slsm_pkg::SLSM_PASS_REINT) else $error("reint missed"); // RL9
  a_reint_fault: assert property (@(posedge pclk) disable iff (!presetn) cur == slsm_pkg::SLSM_PASS_REINT && comm_fault && !fatal && !reboot && !(tool && !motor) |=> cur == slsm_pkg::SLSM_PASS) else $error("fault missed"); // RL7
  a_oper_fault: assert property (@(posedge pclk) disable iff (!presetn) cur == slsm_pkg::SLSM_OPER && comm_fault && !fatal && !reboot && !(tool && !motor) |=> cur == slsm_pkg::SLSM_PASS) else $error("oper fault missed"); // RL17
  a_wd_bound: assert property (@(posedge pclk) disable iff (!presetn) wd_cnt < 32'(WD_CYC)) else $error("watchdog overrun"); // RL13
  a_dat_reply: assert property (@(posedge pclk) disable iff (!presetn) dat_exp && !frame_rise |=> frame_tx && !dat_busy) else $error("no reply"); // RL14

endmodule

`default_nettype wire
